//--- sim/cpu_bus_model.sv
// Bus master model issuing one-cycle strobes and reset requests
`default_nettype none
module cpu_bus_model
   import sram_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic ack,
   input wire logic [31:0] rdata,
   output logic [ADDR_W-1:0] addr,
   output logic [31:0] wdata,
   output logic wr,
   output logic rd,
   output logic [1:0] size,
   output logic supervisor,
   output logic program_space,
   output logic sync_rst
);
   timeunit 1ns;
   timeprecision 100ps;
   logic seen, seen2;
   logic [31:0] got;
   initial begin
      {addr, wdata, wr, rd, size, supervisor, program_space, sync_rst} = '0;
   end
   // One access; rs bit 0 raises reset with the strobe, bit 1 in the second word
   task automatic access(input logic w, input logic [1:0] sz, input logic [ADDR_W-1:0] a,
      input logic [31:0] d, input logic sv, input logic ps, input logic [1:0] rs);
      @(posedge clk);
      {addr, wdata, size, supervisor, program_space, sync_rst} <= {a, d, sz, sv, ps, rs[0]};
      wr <= w;
      rd <= !w;
      @(posedge clk);
      {wr, rd, sync_rst} <= 3'h0;
      // Released lines flip so stale values cannot pass
      addr <= ~a;
      wdata <= ~d;
      #1 seen = ack;
      got = rdata;
      seen2 = 1'b0;
      // No strobe while the long access is busy
      if (sz == SZ_LONG) begin
         @(posedge clk);
         sync_rst <= rs[1];
         @(posedge clk);
         sync_rst <= 1'b0;
         #1 seen2 = ack;
         got = rdata;
      end
   endtask : access
endmodule : cpu_bus_model
`default_nettype wire

//--- sim/ram_ctrl_assertions.sv
// Port-level assertions for the standby RAM control block
`default_nettype none
module ram_ctrl_checker
   import sram_ctrl_pkg::*;
#(
   parameter logic [ADDR_W-1:0] REG_BASE = 24'hfffb40
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sync_rst,
   input wire logic standby_supply,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [1:0] size,
   input wire logic supervisor,
   input wire logic program_space,
   input wire logic ack,
   input wire logic busy,
   input wire logic stop_mode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic strobe;
   logic in_regs;
   // Fresh request, and whether it aims at the register block
   assign strobe = (rd || wr) && !busy;
   assign in_regs = addr[ADDR_W-1:REG_AW] == REG_BASE[ADDR_W-1:REG_AW];
   ////////////////////////////////////////////////////////////////////////////
   a_ack_has_cause: assert property (ack |-> $past(rd || wr) || $past(busy))
      else $error("ack without a request");
   a_stop_blocks: assert property (strobe && stop_mode && !in_regs |=> !ack)
      else $error("array answered in stop");
   a_standby_blocks: assert property (strobe && standby_supply && !in_regs |=> !ack)
      else $error("array answered on standby supply");
   // Stop held so that the array cannot answer in the register window
   a_user_regs: assert property (strobe && in_regs && stop_mode
      && (!supervisor || program_space) |=> !ack)
      else $error("register block answered a non supervisor data cycle");
   a_long_two: assert property ((strobe && size == SZ_LONG && !sync_rst) ##1
      (ack && !sync_rst) ##1 !sync_rst |-> busy ##1 (ack && !busy))
      else $error("long access not two word cycles");
   a_reset_state: assert property ($rose(rst_n) |-> stop_mode && !ack && !busy)
      else $error("wrong state after reset");
   a_sync_idle: assert property (sync_rst && !rd && !wr && !busy |=> stop_mode)
      else $error("idle sync reset not taken");
   a_sync_word: assert property (sync_rst && strobe && size != SZ_LONG |-> ##2 stop_mode)
      else $error("sync reset lost after word access");
   a_stop_clear: assert property ($fell(stop_mode) |->
      $past(wr && supervisor && !program_space))
      else $error("stop cleared without supervisor write");
   c_long: cover property (strobe && size == SZ_LONG ##1 ack);
   c_sync: cover property (sync_rst && strobe);
   c_standby: cover property (strobe && standby_supply);
endmodule : ram_ctrl_checker
bind standby_ram_module_control ram_ctrl_checker #(.REG_BASE(REG_BASE)) chk (.clk, .rst_n,
   .sync_rst, .standby_supply, .addr, .wr, .rd, .size, .supervisor, .program_space, .ack,
   .busy, .stop_mode);
`default_nettype wire

//--- sim/standby_ram_module_control_test.sv
// Self-checking bench for the standby RAM control block
`default_nettype none
module standby_ram_module_control_test;
   import sram_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [ADDR_W-1:0] RB = 24'hfffb40;
   localparam logic [ADDR_W-1:0] AB = 24'h010000;
   typedef struct packed {
      logic w;
      logic [1:0] sz;
      logic [ADDR_W-1:0] a;
      logic [31:0] d;
      logic k;
      logic k2;
   } row_type;
   logic clk, rst_n, standby_supply, sync_rst, wr, rd, supervisor, program_space, ack, busy;
   logic stop_mode;
   logic [ADDR_W-1:0] addr;
   logic [31:0] wdata, rdata;
   logic [1:0] size;
   int n_mismatch, checked;
   logic [31:0] msk;
   row_type rows [17];
   ////////////////////////////////////////////////////////////////////////////
   standby_ram_module_control #(.REG_BASE(RB)) uut (.clk, .rst_n, .sync_rst, .standby_supply,
      .addr, .wdata, .wr, .rd, .size, .supervisor, .program_space, .rdata, .ack, .busy,
      .stop_mode);
   cpu_bus_model m (.clk, .ack, .rdata, .addr, .wdata, .wr, .rd, .size, .supervisor,
      .program_space, .sync_rst);
   always #12.5 clk = ~clk;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrap_up();
      $display("checked %0d, n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   // Supervisor data register write, and a word read of any place
   task automatic rg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      m.access(1'b1, SZ_WORD, a, d, 1'b1, 1'b0, 2'h0);
   endtask : rg
   task automatic rdw(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
      m.access(1'b0, SZ_WORD, a, 32'h0, 1'b1, 1'b0, 2'h0);
      check(what, m.got & 32'hffff, exp);
   endtask : rdw
   ////////////////////////////////////////////////////////////////////////////
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      {clk, rst_n, standby_supply} = 3'h0;
      rows = '{'{'0, SZ_WORD, RB, 32'h8100, '1, '0}, '{'0, SZ_WORD, RB + 24'h2, 0, '1, '0},
         '{'0, SZ_WORD, RB + 24'h4, 0, '1, '0}, '{'1, SZ_WORD, RB + 24'h4, 1, '1, '0},
         '{'1, SZ_WORD, RB, 0, '1, '0}, '{'1, SZ_WORD, RB + 24'h4, 2, '1, '0},
         '{'0, SZ_WORD, RB + 24'h4, 1, '1, '0}, '{'1, SZ_WORD, AB + 24'h2, 32'hbeef, '1, '0},
         '{'0, SZ_WORD, AB + 24'h2, 32'hbeef, '1, '0}, '{'1, SZ_BYTE, AB + 24'h5, 32'h5a, '1, '0},
         '{'0, SZ_BYTE, AB + 24'h5, 32'h5a, '1, '0}, '{'1, SZ_BYTE, AB + 24'h4, 32'ha5, '1, '0},
         '{'0, SZ_WORD, AB + 24'h4, 32'ha55a, '1, '0}, '{'0, SZ_WORD, AB + 24'h1002, 0, '0, '0},
         '{'1, SZ_LONG, AB + 24'h8, 32'h12345678, '1, '1},
         '{'0, SZ_WORD, AB + 24'h8, 32'h1234, '1, '0},
         '{'0, SZ_LONG, AB + 24'h8, 32'h12345678, '1, '1}};
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // Ordinary register and array cases
      foreach (rows[i]) begin
         m.access(rows[i].w, rows[i].sz, rows[i].a, rows[i].d, 1'b1, 1'b0, 2'h0);
         check("ack", {31'h0, m.seen}, {31'h0, rows[i].k});
         check("second ack", {31'h0, m.seen2}, {31'h0, rows[i].k2});
         if (!rows[i].w && rows[i].k) begin
            msk = rows[i].sz == SZ_BYTE ? 32'hff : 32'hffff;
            msk = rows[i].sz == SZ_LONG ? 32'hffffffff : msk;
            check("rdata", m.got & msk, rows[i].d);
         end
      end
      // Every space code against every mode and space
      for (int c = 0; c < 4; c++) begin
         rg(RB, c << 8);
         for (int k = 0; k < 4; k++) begin
            m.access(1'b0, SZ_WORD, AB + 24'h2, 32'h0, k[1], k[0], 2'h0);
            check("space", {31'h0, m.seen}, {31'h0, (!c[1] || k[1]) && (!c[0] || k[0])});
         end
      end
      rg(RB, 32'h0);
      @(posedge clk);
      standby_supply <= 1'b1;
      m.access(1'b0, SZ_WORD, AB + 24'h2, 32'h0, 1'b1, 1'b0, 2'h0);
      check("standby", {31'h0, m.seen}, 32'h0);
      @(posedge clk);
      standby_supply <= 1'b0;
      // Stop refuses a write and keeps the data
      rg(RB, 32'h8000);
      rg(AB + 24'h2, 32'h1111);
      check("stop write", {31'h0, m.seen}, 32'h0);
      rg(RB, 32'h0);
      rdw(AB + 24'h2, 32'hbeef, "kept");
      // Sync reset in a word, then in each half of a long access
      m.access(1'b0, SZ_WORD, AB + 24'h2, 32'h0, 1'b1, 1'b0, 2'h1);
      check("word done", {31'h0, m.seen}, 32'h1);
      rdw(RB, 32'h8100, "config after sync reset");
      rg(RB + 24'h4, 32'h1);
      rg(RB, 32'h0);
      m.access(1'b1, SZ_LONG, AB + 24'h10, 32'hcafe0000, 1'b1, 1'b0, 2'h1);
      check("first word", {31'h0, m.seen}, 32'h1);
      check("no second", {31'h0, m.seen2}, 32'h0);
      rg(RB + 24'h4, 32'h1);
      rg(RB, 32'h0);
      m.access(1'b0, SZ_LONG, AB + 24'h8, 32'h0, 1'b1, 1'b0, 2'h2);
      check("whole long", m.got, 32'h12345678);
      // Register block shut to user and program cycles, with the array stopped
      m.access(1'b0, SZ_WORD, RB, 32'h0, 1'b0, 1'b0, 2'h0);
      check("user reg", {31'h0, m.seen}, 32'h0);
      m.access(1'b0, SZ_WORD, RB, 32'h0, 1'b1, 1'b1, 2'h0);
      check("program reg", {31'h0, m.seen}, 32'h0);
      // Array laid over the register block hides the registers
      rg(RB + 24'h4, 32'hff);
      rg(RB + 24'h6, 32'hf000);
      m.access(1'b0, SZ_WORD, RB, 32'h0, 1'b1, 1'b0, 2'h0);
      check("overlap", {31'h0, m.seen}, 32'h0);
      // An idle sync reset is the way back; the long strobe finds no target
      m.access(1'b0, SZ_LONG, 24'h000000, 32'h0, 1'b1, 1'b0, 2'h2);
      check("no target", {31'h0, m.seen}, 32'h0);
      rdw(RB, 32'h8100, "config after idle reset");
      // Lock sticks and freezes the base
      rg(RB, 32'h8800);
      rg(RB + 24'h4, 32'h3);
      rg(RB, 32'h8000);
      rdw(RB + 24'h4, 32'h0, "locked base");
      rdw(RB, 32'h8800, "lock kept");
      wrap_up();
   end
endmodule : standby_ram_module_control_test
`default_nettype wire

//--- verilog/sram_ctrl_pkg.sv
// Constants, types and field layout of the standby RAM control block
`default_nettype none
package sram_ctrl_pkg;
   localparam int ADDR_W = 24;
   localparam int WORD_AW = 11;          // 2048 words of 16 bits
   localparam int ARRAY_WORDS = 2048;
   localparam int BLK_LSB = 12;          // 4 Kbyte region granule
   localparam int REG_AW = 3;            // eight-byte register block
   // Register word offsets inside the block
   localparam logic [2:0] OFS_CONFIG = 3'h0;
   localparam logic [2:0] OFS_TEST = 3'h2;
   localparam logic [2:0] OFS_BASE_HI = 3'h4;
   localparam logic [2:0] OFS_BASE_LO = 3'h6;
   // Config register fields
   localparam int STOP_BIT = 15;
   localparam int LOCK_BIT = 11;
   localparam int SPACE_LSB = 8;
   // Base register fields
   localparam int BASE_HI_W = 8;         // address bits 23:16
   localparam int BASE_LO_LSB = 12;      // address bits 15:12 in bits 15:12
   localparam int BASE_LO_W = 4;
   // Reset values
   localparam logic STOP_RST = 1'b1;
   localparam logic LOCK_RST = 1'b0;
   localparam logic [1:0] SPACE_RST = 2'h1;
   localparam logic [7:0] BASE_HI_RST = 8'h00;
   localparam logic [3:0] BASE_LO_RST = 4'h0;
   localparam logic [ADDR_W-1:0] WORD_STEP = 24'h000002;
   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_WORD = 2'b01,
      SZ_LONG = 2'b10
   } size_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_GAP = 2'b01,
      ST_SECOND = 2'b10
   } state_type;
endpackage : sram_ctrl_pkg
`default_nettype wire

//--- verilog/standby_ram_module_control.sv
// Standby RAM control: array, register block, space checks, stop and reset handling
//
// The register addresses and the address-and-strobe port were decided locally.
`default_nettype none
module standby_ram_module_control
   import sram_ctrl_pkg::*;
#(
   parameter logic [ADDR_W-1:0] REG_BASE = 24'hfffb40
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sync_rst,
   input wire logic standby_supply,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [1:0] size,
   input wire logic supervisor,
   input wire logic program_space,
   output logic [31:0] rdata,
   output logic ack,
   output logic busy,
   output logic stop_mode
);

   ////////////////////////////////////////////////////////////////////////
   // Functions
   // Space field check against cycle attributes
   function automatic logic space_ok(input logic [1:0] fld, input logic sup,
                                     input logic prog);
      unique case (fld)
         2'h0: space_ok = 1'b1;
         2'h1: space_ok = prog;
         2'h2: space_ok = sup;
         2'h3: space_ok = sup & prog;
      endcase
   endfunction : space_ok

   // Merge byte lanes; lane 1 is the even (high) byte
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                         input logic [1:0] lanes);
      merge = {lanes[1] ? nw[15:8] : old[15:8], lanes[0] ? nw[7:0] : old[7:0]};
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [15:0] mem_r [ARRAY_WORDS];
   logic stop_r;
   logic lock_r;
   logic [1:0] space_r;
   logic [7:0] base_hi_r;
   logic [3:0] base_lo_r;
   state_type state_r;
   // Second-word copy of the request
   logic [ADDR_W-1:0] laddr_r;
   logic [15:0] lwdata_r;
   logic lread_r;
   logic lsup_r;
   logic lprog_r;
   logic pend_r;
   logic ack_r;
   logic [31:0] rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // Current word operation
   logic op_go;
   logic op_first_long;
   logic [ADDR_W-1:0] op_addr;
   logic [15:0] op_wdata;
   logic [1:0] op_lanes;
   logic op_read;
   logic op_sup;
   logic op_prog;
   logic soft_go;
   logic rst_req;

   // Reset request, live or held back from an earlier edge
   assign rst_req = sync_rst | pend_r;

   // Idle strobes start an op unless a held reset takes this cycle
   always_comb begin
      op_go = 1'b0;
      op_first_long = 1'b0;
      op_addr = addr;
      op_wdata = wdata[15:0];
      op_lanes = 2'b11;
      op_read = rd;
      op_sup = supervisor;
      op_prog = program_space;
      if (state_r == ST_SECOND) begin
         op_go = 1'b1;
         op_addr = laddr_r;
         op_wdata = lwdata_r;
         op_read = lread_r;
         op_sup = lsup_r;
         op_prog = lprog_r;
      end else if (state_r == ST_IDLE && !pend_r && (wr || rd)) begin
         op_go = 1'b1;
         if (size == SZ_LONG) begin
            op_first_long = 1'b1;
            op_wdata = wdata[31:16];
         end else if (size == SZ_BYTE) begin
            op_lanes = addr[0] ? 2'b01 : 2'b10;
            op_wdata = {wdata[7:0], wdata[7:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   logic region_hit;
   logic array_ok;
   logic reg_sel;
   logic reg_hit;
   logic [REG_AW-1:0] reg_ofs;
   logic [WORD_AW-1:0] word_idx;

   assign region_hit = op_addr[ADDR_W-1:BLK_LSB] == {base_hi_r, base_lo_r};
   assign array_ok = region_hit & space_ok(space_r, op_sup, op_prog)
                     & ~stop_r & ~standby_supply;
   assign reg_sel = op_addr[ADDR_W-1:REG_AW] == REG_BASE[ADDR_W-1:REG_AW];
   // Overlapped array region hides the registers, even when the array refuses; registers only in supervisor data space
   assign reg_hit = reg_sel & ~region_hit & op_sup & ~op_prog;
   assign reg_ofs = {op_addr[REG_AW-1:1], 1'b0};
   assign word_idx = op_addr[WORD_AW:1];

   // Register read mux; unused places read zero
   logic [15:0] reg_rd;
   always_comb begin
      reg_rd = 16'h0000;
      if (reg_ofs == OFS_CONFIG) begin
         reg_rd[STOP_BIT] = stop_r;
         reg_rd[LOCK_BIT] = lock_r;
         reg_rd[SPACE_LSB +: 2] = space_r;
      end else if (reg_ofs == OFS_TEST) begin
         // Test register is reserved here and reads zero
         reg_rd = 16'h0000;
      end else if (reg_ofs == OFS_BASE_HI) begin
         reg_rd[BASE_HI_W-1:0] = base_hi_r;
      end else if (reg_ofs == OFS_BASE_LO) begin
         reg_rd[BASE_LO_LSB +: BASE_LO_W] = base_lo_r;
      end
   end

   // Shared read path; registers reuse the byte-lane merge
   logic [15:0] word_rd;
   logic [15:0] wr_val;
   logic op_acc;
   logic reg_wr;

   // Array wins the read path only when the access is allowed
   assign word_rd = array_ok ? mem_r[word_idx] : reg_rd;
   assign wr_val = merge(word_rd, op_wdata, op_lanes);
   assign op_acc = op_go & (array_ok | reg_hit);
   assign reg_wr = op_go & ~op_read & ~array_ok & reg_hit;

   ////////////////////////////////////////////////////////////////////////
   // Array storage; no write while stopped or on standby supply
   // Contents are never reset, so data survive both reset kinds
   always_ff @(posedge clk) begin
      if (op_go && !op_read && array_ok) begin
         mem_r[word_idx] <= wr_val;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Synchronous reset: applied only between words, when idle or in the gap of a long access
   // Cutting a word in half would tear the data, so the reset waits
   always_comb begin
      soft_go = 1'b0;
      if (state_r == ST_IDLE && rst_req && !op_go) begin
         soft_go = 1'b1;
      end else if (state_r == ST_GAP && rst_req) begin
         soft_go = 1'b1;
      end
   end

   // Pending reset held until the running word is done
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
      end else if (soft_go) begin
         pend_r <= 1'b0;
      end else if (sync_rst) begin
         pend_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Config register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_r <= STOP_RST;
         lock_r <= LOCK_RST;
         space_r <= SPACE_RST;
      end else if (soft_go) begin
         stop_r <= STOP_RST;
         lock_r <= LOCK_RST;
         space_r <= SPACE_RST;
      end else if (reg_wr && reg_ofs == OFS_CONFIG) begin
         // Register path needs supervisor, so stop only clears from there
         stop_r <= wr_val[STOP_BIT];
         lock_r <= lock_r | wr_val[LOCK_BIT];
         space_r <= wr_val[SPACE_LSB +: 2];
      end
   end

   // Base registers; moving the array needs stop and no lock
   // Lock guards against a stray remap by runaway software
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         base_hi_r <= BASE_HI_RST;
         base_lo_r <= BASE_LO_RST;
      end else if (soft_go) begin
         base_hi_r <= BASE_HI_RST;
         base_lo_r <= BASE_LO_RST;
      end else if (reg_wr && stop_r && !lock_r) begin
         if (reg_ofs == OFS_BASE_HI) begin
            base_hi_r <= wr_val[BASE_HI_W-1:0];
         end
         if (reg_ofs == OFS_BASE_LO) begin
            base_lo_r <= wr_val[BASE_LO_LSB +: BASE_LO_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Long-word sequencer: word, gap cycle with ack, second word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (op_acc && op_first_long) begin
                  state_r <= ST_GAP;
               end
            end
            ST_GAP: begin
               // A reset here drops the second word
               state_r <= rst_req ? ST_IDLE : ST_SECOND;
            end
            ST_SECOND: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Second-word attributes captured with the first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         laddr_r <= '0;
         lwdata_r <= 16'h0000;
         lread_r <= 1'b0;
         lsup_r <= 1'b0;
         lprog_r <= 1'b0;
      end else if (state_r == ST_IDLE && op_first_long) begin
         laddr_r <= addr + WORD_STEP;
         lwdata_r <= wdata[15:0];
         lread_r <= rd;
         lsup_r <= supervisor;
         lprog_r <= program_space;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Acknowledge and read data, one cycle after each word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= op_acc;
      end
   end

   // Read data; long reads fill the high half first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 32'h00000000;
      end else if (op_acc && op_read) begin
         if (op_first_long) begin
            rdata_r <= {word_rd, 16'h0000};
         end else if (state_r == ST_SECOND) begin
            rdata_r <= {rdata_r[31:16], word_rd};
         end else if (size == SZ_BYTE) begin
            rdata_r <= {24'h000000, op_addr[0] ? word_rd[7:0] : word_rd[15:8]};
         end else begin
            rdata_r <= {16'h0000, word_rd};
         end
      end
   end

   // Outputs; busy warns the master off during a long access
   assign rdata = rdata_r;
   assign ack = ack_r;
   assign busy = state_r != ST_IDLE;
   assign stop_mode = stop_r;

endmodule : standby_ram_module_control
`default_nettype wire
